/* File: common/dot_pkg.sv */
// package: constants and types for the on-die termination controller
package dot_pkg;
  // mode register layout
  localparam int          TERM_DQ_LSB      = 0;
  localparam int          TERM_DQ_MSB      = 3;
  localparam int          TERM_DQ_EN_BIT   = 3;
  localparam int          TERM_CA_LSB      = 4;
  localparam int          TERM_CA_MSB      = 6;
  localparam logic [7:0]  TERM_MODE_RESET  = 8'h00;
  localparam logic [2:0]  CA_CODE_MIN      = 3'h1;
  localparam logic [2:0]  CA_CODE_MAX      = 3'h6;
  localparam int          CA_REF_OHM       = 240;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0]  ADDR_TERM_MODE   = 4'h0;
  localparam logic [3:0]  ADDR_CONFIG      = 4'h4;
  localparam logic [3:0]  ADDR_STATUS      = 4'h8;
  localparam logic [3:0]  ADDR_CA_OHM      = 4'hC;
  // config register fields
  localparam int          CFG_BAND_LSB     = 0;
  localparam int          CFG_WLSET_BIT    = 3;
  localparam int          CFG_BL32_BIT     = 4;
  localparam int          CFG_WLEV_BIT     = 5;
  localparam int          CFG_LPM_BIT      = 6;
  localparam logic [7:0]  CONFIG_RESET     = 8'h00;
  // frequency bands (upper limit MHz)
  typedef enum logic [2:0] {
    DOT_B266  = 3'b000,
    DOT_B533  = 3'b001,
    DOT_B800  = 3'b010,
    DOT_B1066 = 3'b011,
    DOT_B1333 = 3'b100,
    DOT_B1600 = 3'b101,
    DOT_B1866 = 3'b110,
    DOT_B2133 = 3'b111
  } dot_band_t;
  localparam int          BL32_EXTRA_CK    = 8;
  // settle times in picoseconds
  localparam int          SETTLE_MIN_PS    = 1500;
  localparam int          SETTLE_MAX_PS    = 3500;
  localparam int          CLK_PERIOD_PS    = 40000;
  // least time rounds up, never below one cycle
  localparam int SETTLE_ON_CYC =
    (SETTLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest time rounds down, floored at one cycle
  localparam int SETTLE_MAX_RAW = SETTLE_MAX_PS / CLK_PERIOD_PS;
  localparam int SETTLE_FULL_CYC = (SETTLE_MAX_RAW < 1) ? 1 : SETTLE_MAX_RAW;
  // column command codes on the command bus
  typedef enum logic [2:0] {
    DOT_CMD_NOP   = 3'b000,
    DOT_CMD_WR1   = 3'b001,
    DOT_CMD_MWR1  = 3'b010,
    DOT_CMD_CAS2  = 3'b011,
    DOT_CMD_MRW   = 3'b100
  } dot_cmd_t;
endpackage

/* File: common/dot_cmd_if.sv */
// interface: decoded command events from the link sampler
`timescale 1ns/1ps
interface dot_cmd_if;
  logic              cmd_valid;
  dot_pkg::dot_cmd_t cmd;
  logic [7:0]        data;
  modport src (output cmd_valid, output cmd, output data);
  modport dst (input cmd_valid, input cmd, input data);
endinterface

/* File: hw/dot_link_rx.sv */
// link sampler: synchronises command clock and bus, emits one event per rising edge that carries a command other than NOP
`timescale 1ns/1ps
module dot_link_rx
  import dot_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ca_clk,
  input  wire logic [2:0] ca_cmd,
  input  wire logic [7:0] ca_data,
  dot_cmd_if.src          ev
);
  logic [2:0]  clk_sync_reg;
  logic [2:0]  cmd_s1_reg;
  logic [2:0]  cmd_s2_reg;
  logic [7:0]  dat_s1_reg;
  logic [7:0]  dat_s2_reg;
  logic        rise;

  // extra clock stage only for edge detection; the edge is seen at the same depth as the bus stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_sync_reg <= 3'h0;
      cmd_s1_reg   <= 3'h0;
      cmd_s2_reg   <= 3'h0;
      dat_s1_reg   <= 8'h00;
      dat_s2_reg   <= 8'h00;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], ca_clk};
      cmd_s1_reg   <= ca_cmd;
      cmd_s2_reg   <= cmd_s1_reg;
      dat_s1_reg   <= ca_data;
      dat_s2_reg   <= dat_s1_reg;
    end
  end

  assign rise = clk_sync_reg[1] & ~clk_sync_reg[2];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev.cmd_valid <= 1'b0;
      ev.cmd       <= DOT_CMD_NOP;
      ev.data      <= 8'h00;
    end else begin
      ev.cmd_valid <= rise && (cmd_s2_reg != DOT_CMD_NOP);
      ev.cmd       <= dot_cmd_t'(cmd_s2_reg);
      ev.data      <= dat_s2_reg;
    end
  end
endmodule

/* File: hw/dot_lat_lut.sv */
// latency lookup: band, write latency set, burst length to on/off cycles
`timescale 1ns/1ps
module dot_lat_lut
  import dot_pkg::*;
(
  input  wire dot_band_t  band,
  input  wire logic       write_latency_set_b,
  input  wire logic       bl32,
  output logic [5:0]      on_lat,
  output logic [5:0]      off_lat,
  output logic            lat_ok
);
  logic [5:0] base_off;
  always_comb begin
    on_lat   = 6'h00;
    base_off = 6'h00;
    lat_ok   = 1'b1;
    case (band)
      DOT_B800:  begin
        on_lat   = 6'h06;
        base_off = 6'h16;
        lat_ok   = write_latency_set_b;
      end
      DOT_B1066: begin
        on_lat   = write_latency_set_b ? 6'h0C : 6'h04;
        base_off = write_latency_set_b ? 6'h1C : 6'h14;
      end
      DOT_B1333: begin
        on_lat   = write_latency_set_b ? 6'h0E : 6'h04;
        base_off = write_latency_set_b ? 6'h20 : 6'h16;
      end
      DOT_B1600: begin
        on_lat   = write_latency_set_b ? 6'h12 : 6'h06;
        base_off = write_latency_set_b ? 6'h24 : 6'h18;
      end
      DOT_B1866: begin
        on_lat   = write_latency_set_b ? 6'h14 : 6'h06;
        base_off = write_latency_set_b ? 6'h28 : 6'h1A;
      end
      DOT_B2133: begin
        on_lat   = write_latency_set_b ? 6'h18 : 6'h08;
        base_off = write_latency_set_b ? 6'h2C : 6'h1C;
      end
      default:   lat_ok = 1'b0;
    endcase
    off_lat = bl32 ? 6'(base_off + 6'(BL32_EXTRA_CK)) : base_off;
  end
endmodule

/* File: hw/dot_term_ctrl.sv */
// top: on-die termination controller with wishbone register access
//
// Operation
// - termination on data, strobes and mask is driven by commands, strobes also by write leveling
// - termination forced off in power-down or self-refresh
// - data termination active when bit 3 set, whatever bits 2:0 hold; off when bit 3 clear
// - command/address code 001..110 selects 240 ohm divided by 1..6
// - idle high impedance; on per write after its second column command, off after burst
// - on latency counted from second column command, then settle window
// - off latency counted from second column command, then settle window
// - latencies from frequency band and write latency set table
// - burst length 32 adds eight cycles to off latency
// - write leveling with termination enabled: strobes on, data off
// - write leveling with termination disabled: strobes and data off
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module dot_term_ctrl
  import dot_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_ON_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ca_clk,
  input  wire logic [2:0]  ca_cmd,
  input  wire logic [7:0]  ca_data,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             term_dq_en,
  output logic             term_dqs_en,
  output logic             term_dmi_en,
  output logic [2:0]       term_dq_code,
  output logic [2:0]       term_ca_div
);
  typedef enum logic [1:0] {
    DOT_IDLE   = 2'b00,
    DOT_ARMED  = 2'b01,
    DOT_COUNT  = 2'b10
  } dot_state_t;

  dot_cmd_if  ev ();
  dot_state_t state_reg;
  logic [7:0] term_mode_reg;
  logic [7:0] config_reg;
  logic [5:0] cnt_reg;
  logic [5:0] on_lat;
  logic [5:0] off_lat;
  logic       lat_ok;
  logic       dq_on_reg;
  logic       settled;
  logic       mode_en;
  logic       lpm;
  logic       wlev;
  logic       wb_req;
  logic       wb_wr;
  logic       in_count;
  logic [7:0] wb_byte0;

  // one stage per settle cycle; a few stages keep the shift cheap
  logic [SETTLE_CYC-1:0] settle_reg;

  if (SETTLE_CYC < 1 || SETTLE_CYC > 8) begin : g_settle_chk
    $error("settle stage count out of range");
  end

  dot_link_rx u_rx (
    .clk     (clk),
    .rst_b   (rst_b),
    .ca_clk  (ca_clk),
    .ca_cmd  (ca_cmd),
    .ca_data (ca_data),
    .ev      (ev)
  );

  dot_lat_lut u_lut (
    .band     (dot_band_t'(config_reg[CFG_BAND_LSB +: 3])),
    .write_latency_set_b (config_reg[CFG_WLSET_BIT]),
    .bl32     (config_reg[CFG_BL32_BIT]),
    .on_lat   (on_lat),
    .off_lat  (off_lat),
    .lat_ok   (lat_ok)
  );

  function automatic logic ca_code_ok(input logic [2:0] c);
    return (c >= CA_CODE_MIN) && (c <= CA_CODE_MAX);
  endfunction

  assign mode_en = term_mode_reg[TERM_DQ_EN_BIT];
  assign lpm     = config_reg[CFG_LPM_BIT];
  assign wlev    = config_reg[CFG_WLEV_BIT];
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write lands only at the edge at which the master sees ack
  assign wb_wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign in_count = (state_reg == DOT_COUNT);
  assign wb_byte0 = wb_dat_i[7:0];
  assign settled  = settle_reg[SETTLE_CYC-1];

  // mode register: written by mode-register write command or by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term_mode_reg <= TERM_MODE_RESET;
    end else if (ev.cmd_valid && ev.cmd == DOT_CMD_MRW) begin
      term_mode_reg <= ev.data;
    end else if (wb_wr && wb_adr_i == ADDR_TERM_MODE
                 && wb_sel_i[0]) begin
      term_mode_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_reg <= CONFIG_RESET;
    end else if (wb_wr && wb_adr_i == ADDR_CONFIG
                 && wb_sel_i[0]) begin
      config_reg <= wb_dat_i[7:0];
    end
  end

  // write sequencer: first command arms, second column command starts count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= DOT_IDLE;
      cnt_reg   <= 6'h00;
      dq_on_reg <= 1'b0;
    end else if (lpm || !mode_en || wlev) begin
      state_reg <= DOT_IDLE;
      cnt_reg   <= 6'h00;
      dq_on_reg <= 1'b0;
    end else begin
      case (state_reg)
        DOT_IDLE: begin
          if (ev.cmd_valid && (ev.cmd == DOT_CMD_WR1 ||
              ev.cmd == DOT_CMD_MWR1) && lat_ok) begin
            state_reg <= DOT_ARMED;
          end
        end
        DOT_ARMED: begin
          if (ev.cmd_valid && ev.cmd == DOT_CMD_CAS2) begin
            state_reg <= DOT_COUNT;
            cnt_reg   <= 6'h00;
          end
        end
        DOT_COUNT: begin
          cnt_reg <= 6'(cnt_reg + 6'h01);
          if (6'(cnt_reg + 6'h01) == on_lat) begin
            dq_on_reg <= 1'b1;
          end
          if (6'(cnt_reg + 6'h01) == off_lat) begin
            dq_on_reg <= 1'b0;
            state_reg <= DOT_IDLE;
          end
        end
        default: state_reg <= DOT_IDLE;
      endcase
    end
  end

  // settle delay models the switch transition after latency expires
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= SETTLE_CYC'({settle_reg, dq_on_reg});
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term_dq_en   <= 1'b0;
      term_dmi_en  <= 1'b0;
      term_dqs_en  <= 1'b0;
      term_dq_code <= 3'h0;
      term_ca_div  <= 3'h0;
    end else begin
      term_dq_en   <= settled && !lpm;
      term_dmi_en  <= settled && !lpm;
      term_dqs_en  <= !lpm && mode_en && (wlev || settled);
      term_dq_code <= term_mode_reg[2:0];
      term_ca_div  <= ca_code_ok(term_mode_reg[TERM_CA_MSB:TERM_CA_LSB])
                      ? term_mode_reg[TERM_CA_MSB:TERM_CA_LSB]
                      : 3'h0;
    end
  end

  // wishbone slave, ack one cycle after request, unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == ADDR_TERM_MODE) begin
          wb_dat_o <= {24'h000000, term_mode_reg};
        end else if (wb_adr_i == ADDR_CONFIG) begin
          wb_dat_o <= {24'h000000, config_reg};
        end else if (wb_adr_i == ADDR_STATUS) begin
          wb_dat_o <= {27'h0, lat_ok, state_reg, term_dqs_en, term_dq_en};
        end else if (wb_adr_i == ADDR_CA_OHM) begin
          wb_dat_o <= {29'h0, term_ca_div};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // assertions; the delays below assume the default settle depth
  a_lpm_forces_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    lpm |=> !term_dq_en && !term_dqs_en)
    else $error("termination active in low power");
  a_disabled_dq_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    !mode_en |=> ##2 !term_dq_en)
    else $error("data termination with mode off");
  a_wlev_dq_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    wlev |=> ##2 !term_dq_en)
    else $error("data termination during write leveling");
  a_wlev_dqs_on: assert property (
    @(posedge clk) disable iff (!rst_b)
    wlev && mode_en && !lpm |=> term_dqs_en)
    else $error("strobe termination missing in leveling");
  a_wlev_off_dis: assert property (
    @(posedge clk) disable iff (!rst_b)
    wlev && !mode_en |=> ##2 !term_dqs_en)
    else $error("strobe termination with mode off");
  a_ca_code_map: assert property (
    @(posedge clk) disable iff (!rst_b)
    !ca_code_ok(term_mode_reg[TERM_CA_MSB:TERM_CA_LSB])
      |=> term_ca_div == 3'h0)
    else $error("invalid address termination code passed");
  a_mrw_update: assert property (
    @(posedge clk) disable iff (!rst_b)
    ev.cmd_valid && ev.cmd == DOT_CMD_MRW
      |=> term_mode_reg == $past(ev.data))
    else $error("mode register write from link lost");

  // write burst steps: column command, on point, off point
  sequence s_start;
    state_reg == DOT_ARMED && ev.cmd_valid && ev.cmd == DOT_CMD_CAS2
      && !lpm && mode_en && !wlev;
  endsequence
  sequence s_on_due;
    in_count && cnt_reg == on_lat - 6'h01 && on_lat != 6'h00
      && !lpm && mode_en && !wlev;
  endsequence
  sequence s_off_due;
    in_count && cnt_reg == off_lat - 6'h01;
  endsequence

  a_start_count: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_start |=> in_count && cnt_reg == 6'h00)
    else $error("column command did not start the count");
  a_on_latency: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_on_due ##2 !lpm |=> term_dq_en)
    else $error("termination late after on latency");
  a_off_latency: assert property (
    @(posedge clk) disable iff (!rst_b)
    s_off_due |=> ##2 !term_dq_en)
    else $error("termination still on after off latency");
  a_count_bound: assert property (
    @(posedge clk) disable iff (!rst_b)
    in_count |-> cnt_reg < off_lat)
    else $error("burst counter ran past off latency");
  a_on_needs_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(term_dq_en) |-> $past(in_count, 3))
    else $error("termination rose without a write burst");
  a_dq_idle_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    state_reg == DOT_IDLE && !dq_on_reg |=> ##2 !term_dq_en)
    else $error("termination left on when idle");
  a_lpm_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    lpm |=> state_reg == DOT_IDLE)
    else $error("write sequence kept running in low power");
  a_lat_undef: assert property (
    @(posedge clk) disable iff (!rst_b)
    !lat_ok && state_reg == DOT_IDLE |=> state_reg == DOT_IDLE)
    else $error("write accepted with undefined latency");
  a_bl32_extra: assert property (
    @(posedge clk) disable iff (!rst_b)
    lat_ok && config_reg[CFG_BL32_BIT] |-> off_lat > on_lat + 6'h08)
    else $error("burst 32 off latency not extended");

  // register bus handshake
  a_ack_answer: assert property (
    @(posedge clk) disable iff (!rst_b)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_pulse: assert property (
    @(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_wr_lands: assert property (
    @(posedge clk) disable iff (!rst_b)
    wb_wr && wb_adr_i == ADDR_CONFIG && wb_sel_i[0]
      |=> config_reg == $past(wb_byte0))
    else $error("register write did not land at ack");
endmodule

/* File: tb/dot_ca_master.sv */
// memory controller model: frames commands on the command clock
`timescale 1ns/1ps
module dot_ca_master
  import dot_pkg::*;
#(
  parameter int UPD_CYC = 4
)(
  input  wire logic  clk,
  output logic       ca_clk,
  output logic [2:0] ca_cmd,
  output logic [7:0] ca_data
);
  initial begin
    ca_clk = 1'h0;
    ca_cmd = DOT_CMD_NOP;
    ca_data = 8'hA5;
  end

  // one 520 ns frame, 680 ns for a mode-register write; the command clock stands still between frames
  task automatic send(input dot_cmd_t c, input logic [7:0] d);
    ca_cmd  <= c;
    ca_data <= d;
    repeat (4) @(posedge clk);
    ca_clk <= 1'h1;
    repeat (4) @(posedge clk);
    ca_clk <= 1'h0;
    repeat (4) @(posedge clk);
    // released lines show a changed pattern, never the old value
    ca_cmd  <= DOT_CMD_NOP;
    ca_data <= ~d;
    if (c == DOT_CMD_MRW) repeat (UPD_CYC) @(posedge clk);
    @(posedge clk);
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the termination controller
`timescale 1ns/1ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module tb
  import dot_pkg::*;
;
  localparam int ON_L [16] =
    '{-1, -1, -1, -1, -1, 6, 4, 12, 4, 14, 6, 18, 6, 20, 8, 24};
  localparam int OFF_L [16] =
    '{-1, -1, -1, -1, -1, 22, 20, 28, 22, 32, 24, 36, 26, 40, 28, 44};
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, dq, dqs, data_mask_invert_pin, ca_clk, ca_q, dq_q;
  logic        mism = 1'h0;
  logic [2:0]  dq_code, ca_div, ca_cmd;
  logic [7:0]  ca_data;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  int          t_cas = 0, t_on = 0, t_off = 0, n_rise = 0;

  always #20 clk = ~clk;

  dot_term_ctrl u_dut (
    .clk          (clk),
    .rst_b        (rst_b),
    .ca_clk       (ca_clk),
    .ca_cmd       (ca_cmd),
    .ca_data      (ca_data),
    .wb_cyc_i     (cyc_i),
    .wb_stb_i     (stb_i),
    .wb_we_i      (we_i),
    .wb_adr_i     (adr_i),
    .wb_sel_i     (sel_i),
    .wb_dat_i     (dat_i),
    .wb_dat_o     (dat_o),
    .wb_ack_o     (ack_o),
    .term_dq_en   (dq),
    .term_dqs_en  (dqs),
    .term_dmi_en  (data_mask_invert_pin),
    .term_dq_code (dq_code),
    .term_ca_div  (ca_div)
  );

  dot_ca_master u_ctl (
    .clk     (clk),
    .ca_clk  (ca_clk),
    .ca_cmd  (ca_cmd),
    .ca_data (ca_data)
  );

  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // edge times in system cycles, taken at the pins
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ca_q <= ca_clk;
    dq_q <= dq;
    if (ca_clk && !ca_q && ca_cmd == DOT_CMD_CAS2) t_cas <= cyc;
    if (dq === 1'h1 && dq_q === 1'h0) begin
      t_on <= cyc;
      n_rise <= n_rise + 1;
    end
    if (dq === 1'h0 && dq_q === 1'h1) t_off <= cyc;
    if (dqs !== dq || data_mask_invert_pin !== dq) mism <= 1'h1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    if (n >= 50) `CHK(ack_o, 1'h1)
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    sel_i <= 4'h0;
    @(posedge clk);
  endtask

  // one write burst; a negative latency means no termination expected
  task automatic burst(input logic [7:0] c, input int on_l,
                       input int off_l, input dot_cmd_t wc);
    int n, r0;
    n = 0;
    wb(1'h1, ADDR_CONFIG, {24'h0, c});
    r0 = n_rise;
    u_ctl.send(wc, 8'h00);
    u_ctl.send(DOT_CMD_CAS2, 8'h00);
    while (n < 120 && !(n_rise > r0 && dq_q === 1'h0)) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    if (on_l < 0) `CHK(n_rise - r0, 0)
    else begin
      `CHK(t_off - t_on, off_l - on_l)
      `CHK(t_on - t_cas inside {[on_l + 1 : on_l + 6]}, 1'h1)
      `CHK(dq, 1'h0)
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    `CHK({dq, dqs, data_mask_invert_pin, dq_code, ca_div}, 9'h0)
    wb(1'h0, ADDR_TERM_MODE, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'h0, ADDR_CONFIG, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'h0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    for (int c = 0; c < 8; c++) begin
      wb(1'h1, ADDR_TERM_MODE, {24'h0, 1'h0, c[2:0], 1'h0, c[2:0]});
      repeat (2) @(posedge clk);
      `CHK(ca_div, (c >= 1 && c <= 6) ? c[2:0] : 3'h0)
      `CHK(dq_code, c[2:0])
    end
    u_ctl.send(DOT_CMD_MRW, 8'h5C);
    wb(1'h0, ADDR_TERM_MODE, 32'h0);
    `CHK(rd, 32'h5C)
    `CHK(ca_div, 3'h5)
    wb(1'h0, ADDR_CA_OHM, 32'h0);
    `CHK(rd, 32'h5)
    for (int i = 0; i < 16; i++)
      burst({4'h0, i[0], i[3:1]}, ON_L[i], OFF_L[i],
            i[0] ? DOT_CMD_MWR1 : DOT_CMD_WR1);
    burst(8'h1B, 12, 36, DOT_CMD_MWR1);
    `CHK(mism, 1'h0)
    wb(1'h1, ADDR_TERM_MODE, 32'h07);
    burst(8'h0B, -1, -1, DOT_CMD_WR1);
    wb(1'h1, ADDR_TERM_MODE, 32'h0C);
    burst(8'h4B, -1, -1, DOT_CMD_WR1);
    // power-down arriving while termination is on cuts it short
    wb(1'h1, ADDR_CONFIG, 32'h0B);
    u_ctl.send(DOT_CMD_WR1, 8'h00);
    u_ctl.send(DOT_CMD_CAS2, 8'h00);
    for (int n = 0; n < 40 && dq !== 1'h1; n++) @(posedge clk);
    `CHK(dq, 1'h1)
    wb(1'h1, ADDR_CONFIG, 32'h4B);
    repeat (3) @(posedge clk);
    `CHK({dq, dqs, data_mask_invert_pin}, 3'h0)
    repeat (60) @(posedge clk);
    burst(8'h23, -1, -1, DOT_CMD_WR1);
    `CHK({dqs, dq, data_mask_invert_pin}, 3'h4)
    wb(1'h0, ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h12)
    wb(1'h1, ADDR_TERM_MODE, 32'h00);
    repeat (4) @(posedge clk);
    `CHK({dqs, dq, data_mask_invert_pin}, 3'h0)
    end_sim();
  end
endmodule
